// File: rtl/loop_params.svh
// Timing, scale and width constants for the pulse-count temperature loop
// Function
// RULE_01 - Readings sent as low/high current pulses
// RULE_02 - After power-up, quiet low at most 54 ms
// RULE_03 - Pulses run nominally at 88 kHz
// RULE_04 - Repeat forever, new train every 104 ms
// RULE_05 - Transmission window lasts at most 50 ms
// RULE_06 - After last pulse, loop stays low
// RULE_07 - Train holds 1 to 4095 pulses
// RULE_08 - Reader weighs each pulse one sixteenth degree
// RULE_09 - Count 1 under scale, 4096 over
// RULE_10 - Linear: count/4096*256 minus 50 degrees
// RULE_11 - Linear only 25 to 80 degrees
// RULE_12 - Reader counts edges across whole train
// RULE_13 - Power stays off at least 50 ms
// RULE_14 - Pulse rate within 82 to 94 kHz
// RULE_15 - High level 40 to 60 percent
// RULE_16 - Clear on first edge, latch after quiet
// RULE_17 - Reader synchronises and deglitches loop input
`ifndef LOOP_PARAMS_SVH
`define LOOP_PARAMS_SVH

`define CLK_KHZ 125000
`define CONV_MAX_MS 54
`define DATA_MAX_MS 50
`define CYCLE_MAX_MS 104
`define OFF_MIN_MS 50
`define PULSE_KHZ 88
`define PULSE_MIN_KHZ 82
`define PULSE_MAX_KHZ 94
`define DUTY_PCT 50
`define PCT_FULL 100

`define CONV_CYC (`CONV_MAX_MS * `CLK_KHZ)
`define DATA_CYC (`DATA_MAX_MS * `CLK_KHZ)
`define OFF_CYC (`OFF_MIN_MS * `CLK_KHZ)
`define PULSE_CYC (`CLK_KHZ / `PULSE_KHZ)
`define PULSE_MIN_CYC ((`CLK_KHZ + `PULSE_MAX_KHZ - 1) / `PULSE_MAX_KHZ)
`define PULSE_MAX_CYC (`CLK_KHZ / `PULSE_MIN_KHZ)
`define QUIET_PERIODS 4
`define QUIET_CYC (`QUIET_PERIODS * `PULSE_CYC)
`define GLITCH_CYC 64

`define COUNT_W 12
`define TOTAL_W 13
`define TEMP_W 14
`define COUNT_MIN 1
`define COUNT_MAX 4095
`define SCALE_TOP 4096
`define STEPS_PER_C 16
`define ZERO_OFFSET_C 50
`define ZERO_COUNT (`ZERO_OFFSET_C * `STEPS_PER_C)
`define LIN_LO_C 25
`define LIN_HI_C 80
`define LIN_LO_CNT ((`LIN_LO_C + `ZERO_OFFSET_C) * `STEPS_PER_C)
`define LIN_HI_CNT ((`LIN_HI_C + `ZERO_OFFSET_C) * `STEPS_PER_C)

`endif

// File: rtl/loop_pkg.sv
// Types shared by both ends of the pulse-count loop
package loop_pkg;
	typedef enum logic [1:0] {S_OFF, S_CONV, S_SEND, S_TAIL} sensor_state_t;
	typedef enum logic [1:0] {P_REST, P_READY, P_ON} power_state_t;
	typedef logic [11:0] count_t;
	typedef logic [12:0] total_t;
	typedef logic signed [13:0] temp_t;
endpackage

// File: rtl/loop_if.sv
// Two-wire loop between sensor and reader
`timescale 1ns/1ns
interface loop_if;
	logic power_on;
	logic loop_high;
	modport sensor (input power_on, output loop_high);
	modport reader (output power_on, input loop_high);
endinterface

// File: rtl/pulse_sensor.sv
// Sensor end: converts, then sends the count as a current pulse train
`timescale 1ns/1ns
`include "loop_params.svh"
module pulse_sensor #(
	parameter int CONV_CYC = `CONV_CYC,
	parameter int DATA_CYC = `DATA_CYC,
	parameter int PULSE_CYC = `PULSE_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire loop_pkg::count_t temp_count,
	loop_if.sensor loop
);
	import loop_pkg::*;

	localparam int HIGH_CYC = (PULSE_CYC * `DUTY_PCT) / `PCT_FULL;

	generate
		if (PULSE_CYC < 2 || CONV_CYC < 1 ||
			DATA_CYC < `COUNT_MAX * PULSE_CYC)
		begin : g_bad
			$error("pulse_sensor: timing parameters cannot fit a train");
		end
	endgenerate

	sensor_state_t state_r, state_nxt;
	logic [31:0] timer_r, timer_nxt;
	logic [31:0] phase_r, phase_nxt;
	count_t left_r, left_nxt;
	logic pwr_s1_r, pwr_s2_r;
	logic loop_high_r;
	count_t load_count;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			pwr_s1_r <= 1'b0;
			pwr_s2_r <= 1'b0;
		end
		else if (ce)
		begin
			pwr_s1_r <= loop.power_on;
			pwr_s2_r <= pwr_s1_r;
		end
	end

	// A zero reading still sends a one-pulse train the reader flags as under scale
	always_comb
	begin
		if (temp_count < 12'(`COUNT_MIN))
			load_count = 12'(`COUNT_MIN); // RULE_07
		else
			load_count = temp_count;
	end

	always_comb
	begin
		state_nxt = state_r;
		timer_nxt = timer_r + 32'h1;
		phase_nxt = phase_r;
		left_nxt = left_r;
		case (state_r)
			S_OFF:
			begin
				timer_nxt = 32'h0;
				state_nxt = S_CONV;
			end
			S_CONV:
			begin
				if (timer_r >= 32'(CONV_CYC - 1)) // RULE_02
				begin
					state_nxt = S_SEND;
					timer_nxt = 32'h0;
					phase_nxt = 32'h0;
					left_nxt = load_count;
				end
			end
			S_SEND:
			begin
				if (phase_r >= 32'(PULSE_CYC - 1)) // RULE_03 RULE_14
				begin
					phase_nxt = 32'h0;
					left_nxt = left_r - 12'h1;
					if (left_r == 12'(`COUNT_MIN))
						state_nxt = S_TAIL; // RULE_06
				end
				else
					phase_nxt = phase_r + 32'h1;
			end
			S_TAIL:
			begin
				if (timer_r >= 32'(DATA_CYC - 1)) // RULE_05
				begin
					state_nxt = S_CONV; // RULE_04
					timer_nxt = 32'h0;
				end
			end
			default:
				state_nxt = S_OFF;
		endcase
		if (!pwr_s2_r)
			state_nxt = S_OFF;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			state_r <= S_OFF;
		else if (ce)
			state_r <= state_nxt;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			timer_r <= 32'h0;
			phase_r <= 32'h0;
			left_r <= 12'h0;
		end
		else if (ce)
		begin
			timer_r <= timer_nxt;
			phase_r <= phase_nxt;
			left_r <= left_nxt;
		end
	end

	// High for the first part of each period only while sending
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			loop_high_r <= 1'b0;
		else if (ce)
			loop_high_r <= (state_nxt == S_SEND) &&
				(phase_nxt < 32'(HIGH_CYC)); // RULE_01 RULE_15
	end

	assign loop.loop_high = loop_high_r;
endmodule // pulse_sensor

// File: rtl/pulse_reader.sv
// Reader end: powers the loop, counts pulse trains, converts to degrees
`timescale 1ns/1ns
`include "loop_params.svh"
module pulse_reader #(
	parameter int OFF_CYC = `OFF_CYC,
	parameter int QUIET_CYC = `QUIET_CYC,
	parameter int GLITCH_CYC = `GLITCH_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic power_req,
	output logic power_active,
	output loop_pkg::total_t pulse_total,
	output loop_pkg::temp_t temp_sixteenths,
	output logic result_valid,
	output logic under_scale,
	output logic over_scale,
	output logic linear_ok,
	loop_if.reader loop
);
	import loop_pkg::*;

	generate
		if (OFF_CYC < 1 || GLITCH_CYC < 1 ||
			QUIET_CYC <= GLITCH_CYC)
		begin : g_bad
			$error("pulse_reader: quiet time must exceed glitch filter");
		end
	endgenerate

	power_state_t pstate_r;
	logic [31:0] off_cnt_r;
	logic power_r;

	logic loop_s1_r, loop_s2_r;
	logic filt_r, filt_d_r;
	logic [31:0] stab_cnt_r;
	logic rise;

	logic busy_r;
	logic [31:0] quiet_r;
	total_t cnt_r;

	total_t total_r;
	temp_t temp_r;
	logic valid_r;
	logic under_r;
	logic over_r;
	logic lin_r;
	logic latch;

	// Power sequencing: the off time starts at reset as well
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			pstate_r <= P_REST;
			off_cnt_r <= 32'h0;
			power_r <= 1'b0;
		end
		else if (ce)
		begin
			case (pstate_r)
				P_REST:
				begin
					power_r <= 1'b0;
					if (off_cnt_r >= 32'(OFF_CYC - 1)) // RULE_13
						pstate_r <= P_READY;
					else
						off_cnt_r <= off_cnt_r + 32'h1;
				end
				P_READY:
				begin
					if (power_req)
					begin
						pstate_r <= P_ON;
						power_r <= 1'b1;
					end
				end
				P_ON:
				begin
					if (!power_req)
					begin
						pstate_r <= P_REST;
						power_r <= 1'b0;
						off_cnt_r <= 32'h0;
					end
				end
				default:
				begin
					pstate_r <= P_REST;
					power_r <= 1'b0;
					off_cnt_r <= 32'h0;
				end
			endcase
		end
	end

	// Loop level arrives from outside this clock
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			loop_s1_r <= 1'b0;
			loop_s2_r <= 1'b0;
		end
		else if (ce)
		begin
			loop_s1_r <= loop.loop_high; // RULE_17
			loop_s2_r <= loop_s1_r;
		end
	end

	// A level must hold GLITCH_CYC cycles before it is believed
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			filt_r <= 1'b0;
			filt_d_r <= 1'b0;
			stab_cnt_r <= 32'h0;
		end
		else if (ce)
		begin
			filt_d_r <= filt_r;
			if (loop_s2_r == filt_r)
				stab_cnt_r <= 32'h0;
			else if (stab_cnt_r >= 32'(GLITCH_CYC - 1)) // RULE_17
			begin
				filt_r <= loop_s2_r;
				stab_cnt_r <= 32'h0;
			end
			else
				stab_cnt_r <= stab_cnt_r + 32'h1;
		end
	end

	assign rise = filt_r && !filt_d_r;
	assign latch = busy_r && !rise && (quiet_r >= 32'(QUIET_CYC - 1));

	// Gate opens at the first edge, closes after a quiet spell
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			busy_r <= 1'b0;
			cnt_r <= 13'h0;
			quiet_r <= 32'h0;
		end
		else if (ce)
		begin
			if (!power_r)
			begin
				busy_r <= 1'b0;
				quiet_r <= 32'h0;
			end
			else if (rise)
			begin
				quiet_r <= 32'h0;
				busy_r <= 1'b1;
				if (!busy_r)
					cnt_r <= 13'h1; // RULE_16
				else if (cnt_r != 13'(`SCALE_TOP))
					cnt_r <= cnt_r + 13'h1; // RULE_12
			end
			else if (latch)
				busy_r <= 1'b0; // RULE_16
			else if (busy_r)
				quiet_r <= quiet_r + 32'h1;
		end
	end

	// Sixteenths of a degree: count minus the zero-degree count
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			total_r <= 13'h0;
			temp_r <= 14'sh0;
			under_r <= 1'b0;
			over_r <= 1'b0;
			lin_r <= 1'b0;
		end
		else if (ce && latch)
		begin
			total_r <= cnt_r;
			temp_r <= $signed({1'b0, cnt_r}) -
				14'(`ZERO_COUNT); // RULE_08 RULE_10
			under_r <= (cnt_r <= 13'(`COUNT_MIN)); // RULE_09
			over_r <= (cnt_r >= 13'(`SCALE_TOP)); // RULE_09
			lin_r <= (cnt_r >= 13'(`LIN_LO_CNT)) &&
				(cnt_r <= 13'(`LIN_HI_CNT)); // RULE_11
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			valid_r <= 1'b0;
		else if (ce)
			valid_r <= latch;
	end

	assign loop.power_on = power_r;
	assign power_active = power_r;
	assign pulse_total = total_r;
	assign temp_sixteenths = temp_r;
	assign result_valid = valid_r;
	assign under_scale = under_r;
	assign over_scale = over_r;
	assign linear_ok = lin_r;
endmodule // pulse_reader

// File: dv/loop_properties.sv
// Concurrent checks on the loop wires between sensor and reader
`timescale 1ns/1ns
module loop_properties #(
	parameter int CONV_CYC = 200,
	parameter int DATA_CYC = 24600,
	parameter int PULSE_CYC = 6,
	parameter int OFF_CYC = 50
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic power_on,
	input wire logic loop_high
);
	localparam int HI_CYC = PULSE_CYC * 50 / 100;
	localparam int LO_CYC = PULSE_CYC - HI_CYC;
	localparam int CONV_LO = CONV_CYC;
	localparam int CONV_HI = CONV_CYC + 8;
	localparam int REP_LO = DATA_CYC + CONV_CYC - 2;
	localparam int REP_HI = DATA_CYC + CONV_CYC + 4;
	bit hi_q;
	bit started;
	int hi_len;
	int lo_len;
	int on_len;
	int off_len;
	int tr_len;
	int n_pulses;
	logic new_train;
	// A rise after a long quiet gap opens a fresh train
	assign new_train = loop_high && !hi_q && lo_len > LO_CYC;
	always_ff @(posedge clk)
	begin
		hi_q <= loop_high;
		hi_len <= loop_high ? hi_len + 1 : 0;
		lo_len <= loop_high ? 0 : lo_len + 1;
		on_len <= power_on ? on_len + 1 : 0;
		off_len <= (!rst_n || power_on) ? 0 : off_len + 1;
	end
	always_ff @(posedge clk)
	begin
		started <= power_on && (started || new_train);
		tr_len <= new_train ? 0 : tr_len + 1;
		n_pulses <= new_train ? 1 : n_pulses + int'(loop_high && !hi_q);
	end
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	sequence first_rise_s;
		##[CONV_LO:CONV_HI] $rose(loop_high);
	endsequence
	idle_low_a: assert property (!power_on [*6] |-> !loop_high)
		else $error("loop high unpowered");
	conv_time_a: assert property ($rose(power_on) |-> first_rise_s)
		else $error("no train after conversion");
	no_early_a: assert property ($rose(loop_high) |-> on_len >= CONV_CYC)
		else $error("pulse during conversion");
	high_width_a: assert property ($fell(loop_high) |-> hi_len == HI_CYC)
		else $error("bad high width");
	low_gap_a: assert property ($rose(loop_high) |->
		lo_len == LO_CYC || lo_len >= CONV_CYC)
		else $error("bad pulse period");
	train_size_a: assert property (n_pulses <= 4095)
		else $error("train too long");
	window_a: assert property ($rose(loop_high) && !new_train |->
		tr_len < DATA_CYC)
		else $error("pulse past window");
	repeat_time_a: assert property (new_train && started |->
		tr_len >= REP_LO && tr_len <= REP_HI)
		else $error("bad train spacing");
	off_time_a: assert property ($rose(power_on) |-> off_len >= OFF_CYC)
		else $error("power off too short");
endmodule // loop_properties

// File: dv/tb_top.sv
// Bench joining sensor and reader, checking each latched reading
`timescale 1ns/1ns
module tb_top;
	import loop_pkg::*;
	localparam int CONV = 200;
	localparam int DATA = 24600;
	localparam int PULSE = 6;
	localparam int OFF = 50;
	logic clk = 0;
	logic rst_n = 0;
	logic power_req = 0;
	count_t temp_count = 12'h000;
	logic power_active;
	total_t pulse_total;
	temp_t temp_sixteenths;
	logic result_valid;
	logic under_scale;
	logic over_scale;
	logic linear_ok;
	int num_errors = 0;
	int n_checks = 0;
	int rises = 0;
	loop_if lp();
	pulse_sensor #(.CONV_CYC(CONV), .DATA_CYC(DATA), .PULSE_CYC(PULSE))
		pulse_sensor_inst (.clk(clk), .rst_n(rst_n), .ce(1'b1),
		.temp_count(temp_count), .loop(lp));
	pulse_reader #(.OFF_CYC(OFF), .QUIET_CYC(20), .GLITCH_CYC(2))
		pulse_reader_inst (.clk(clk), .rst_n(rst_n), .ce(1'b1),
		.power_req(power_req), .power_active(power_active),
		.pulse_total(pulse_total), .temp_sixteenths(temp_sixteenths),
		.result_valid(result_valid), .under_scale(under_scale),
		.over_scale(over_scale), .linear_ok(linear_ok), .loop(lp));
	loop_properties #(.CONV_CYC(CONV), .DATA_CYC(DATA), .PULSE_CYC(PULSE),
		.OFF_CYC(OFF)) loop_properties_inst (.clk(clk), .rst_n(rst_n),
		.power_on(lp.power_on), .loop_high(lp.loop_high));
	initial forever #4 clk = ~clk;
	always @(posedge lp.loop_high) rises++;
	task automatic end_of_test();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [13:0] got, input logic [13:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[FAIL] %0t got %0h want %0h", $time, got, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wait_rise();
		int k;
		k = 0;
		while (lp.loop_high !== 1'b1 && k < 30000)
		begin
			step(1);
			k++;
		end
	endtask
	// Value is taken at the end of the next conversion, so set it early
	task automatic read_train(input count_t c);
		int n;
		int k;
		n = (c == 0) ? 1 : c;
		temp_count = c;
		k = 0;
		do
		begin
			step(1);
			k++;
		end
		while (result_valid !== 1'b1 && k < 30000);
		chk(result_valid, 14'h0001);
		chk(pulse_total, 14'(n));
		chk(rises, 14'(n));
		chk(temp_sixteenths, 14'(n - 800));
		chk(under_scale, 14'(n <= 1));
		chk(over_scale, 14'h0000);
		chk(linear_ok, 14'(n >= 1200 && n <= 2080));
		rises = 0;
	endtask
	initial
	begin
		step(4);
		rst_n = 1;
		power_req = 1;
		read_train(12'hFFF);
		read_train(12'h4B0);
		read_train(12'h000);
		// Cut power at the first pulse of a train so the loop must fall by itself
		temp_count = 12'h064;
		wait_rise();
		chk(lp.loop_high, 14'h0001);
		power_req = 0;
		step(8);
		chk(lp.loop_high, 14'h0000);
		power_req = 1;
		step(30);
		chk(power_active, 14'h0000);
		step(30);
		chk(power_active, 14'h0001);
		end_of_test();
	end
	initial
	begin
		#800000;
		num_errors++;
		end_of_test();
	end
endmodule // tb_top
